// ===== verilog/host_i2c_controller.sv
`default_nettype none
module host_i2c_controller import i2c_port_pkg::*; (
    input wire logic ref_clk,
    input wire logic sys_rst,
    i2c_link_if.host link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_read,
    input wire logic [7:0] cmd_reg,
    input wire logic [7:0] cmd_wdata,
    output logic resp_valid,
    output logic resp_nack,
    output logic [7:0] resp_rdata
);
    host_state_t state;
    host_state_t next_state;
    logic [8:0] tick_cnt;
    logic [8:0] next_tick_cnt;
    logic tick;
    logic [1:0] q;
    logic [1:0] next_q;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [2:0] step;
    logic [2:0] next_step;
    logic [8:0] tx;
    logic [8:0] next_tx;
    logic [8:0] rx;
    logic [8:0] next_rx;
    logic scl_low;
    logic next_scl_low;
    logic sda_low;
    logic next_sda_low;
    logic rd;
    logic next_rd;
    logic [7:0] regb;
    logic [7:0] next_regb;
    logic [7:0] wdat;
    logic [7:0] next_wdat;
    logic fail;
    logic next_fail;
    logic [1:0] retry;
    logic [1:0] next_retry;
    logic next_resp_valid;
    logic next_resp_nack;
    logic [7:0] next_resp_rdata;
    logic sda_s;

    pin_sync sda_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pin(link.sda),
        .level(sda_s)
    );

    assign link.host_scl_out = 1'b0;
    assign link.host_sda_out = 1'b0;
    assign link.host_scl_oe = scl_low;
    assign link.host_sda_oe = sda_low;
    assign cmd_ready = (state == H_IDLE);
    // quarter-bit tick keeps the bit rate at or under fast mode
    assign tick = (tick_cnt == QTR_LAST);

    // byte sent at each step; step 4 releases sda to read
    function automatic logic [7:0] step_byte(input logic [2:0] s);
        case (s)
            3'h0: step_byte = {TARGET_ADDR, WRITE_BIT};
            3'h1: step_byte = regb;
            3'h2: step_byte = wdat;
            3'h3: step_byte = {TARGET_ADDR, READ_BIT};
            default: step_byte = 8'hff;
        endcase
    endfunction

    always_comb begin
        next_state = state;
        next_tick_cnt = (state == H_IDLE || tick) ? 9'h000 : tick_cnt + 9'h001;
        next_q = q;
        next_bit_cnt = bit_cnt;
        next_step = step;
        next_tx = tx;
        next_rx = rx;
        next_scl_low = scl_low;
        next_sda_low = sda_low;
        next_rd = rd;
        next_regb = regb;
        next_wdat = wdat;
        next_fail = fail;
        next_retry = retry;
        next_resp_valid = 1'b0;
        next_resp_nack = resp_nack;
        next_resp_rdata = resp_rdata;
        case (state)
            H_IDLE: begin
                if (cmd_valid) begin
                    next_rd = cmd_read;
                    next_regb = cmd_reg;
                    next_wdat = cmd_wdata;
                    next_step = 3'h0;
                    next_retry = 2'h0;
                    next_fail = 1'b0;
                    next_q = 2'h0;
                    next_state = H_START;
                end
            end
            H_START: begin
                if (tick) begin
                    next_q = q + 2'h1;
                    case (q)
                        2'h0: next_scl_low = 1'b1;
                        2'h1: next_sda_low = 1'b0;
                        2'h2: next_scl_low = 1'b0;
                        default: begin
                            // sda falls with scl high, then address packet
                            next_sda_low = 1'b1;
                            next_tx = {step_byte(step), 1'b1};
                            next_bit_cnt = 4'h0;
                            next_state = H_BITS;
                        end
                    endcase
                end
            end
            H_BITS: begin
                if (tick) begin
                    next_q = q + 2'h1;
                    case (q)
                        2'h0: next_scl_low = 1'b1;
                        2'h1: next_sda_low = ~tx[8];
                        2'h2: next_scl_low = 1'b0;
                        default: begin
                            next_rx = {rx[7:0], sda_s};
                            next_tx = {tx[7:0], 1'b1};
                            next_bit_cnt = bit_cnt + 4'h1;
                            if (bit_cnt == FRAME_LAST) begin
                                next_bit_cnt = 4'h0;
                                if (step != 3'h4 && sda_s) begin
                                    next_fail = 1'b1;
                                    next_state = H_STOP;
                                end else if (step == 3'h1 && rd) begin
                                    next_step = 3'h3;
                                    next_state = H_START;
                                end else if (step == 3'h2) begin
                                    next_state = H_STOP;
                                end else if (step == 3'h4) begin
                                    // nack was sent in the ninth bit
                                    next_resp_rdata = rx[7:0];
                                    next_state = H_STOP;
                                end else begin
                                    next_step = step + 3'h1;
                                    next_tx = {step_byte(step + 3'h1), 1'b1};
                                end
                            end
                        end
                    endcase
                end
            end
            H_STOP: begin
                if (tick) begin
                    next_q = q + 2'h1;
                    case (q)
                        2'h0: next_scl_low = 1'b1;
                        2'h1: next_sda_low = 1'b1;
                        2'h2: next_scl_low = 1'b0;
                        default: begin
                            next_sda_low = 1'b0;
                            if (fail && retry != RETRY_MAX) begin
                                // repeat the whole transaction
                                next_retry = retry + 2'h1;
                                next_fail = 1'b0;
                                next_step = 3'h0;
                                next_state = H_START;
                            end else begin
                                next_resp_valid = 1'b1;
                                next_resp_nack = fail;
                                next_state = H_IDLE;
                            end
                        end
                    endcase
                end
            end
            default: begin
                next_scl_low = 1'b0;
                next_sda_low = 1'b0;
                next_state = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= H_IDLE;
            tick_cnt <= 9'h000;
            q <= 2'h0;
            bit_cnt <= 4'h0;
            step <= 3'h0;
            tx <= FRAME_RESET;
            rx <= FRAME_RESET;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
            rd <= 1'b0;
            regb <= BYTE_RESET;
            wdat <= BYTE_RESET;
            fail <= 1'b0;
            retry <= 2'h0;
            resp_valid <= 1'b0;
            resp_nack <= 1'b0;
            resp_rdata <= BYTE_RESET;
        end else begin
            state <= next_state;
            tick_cnt <= next_tick_cnt;
            q <= next_q;
            bit_cnt <= next_bit_cnt;
            step <= next_step;
            tx <= next_tx;
            rx <= next_rx;
            scl_low <= next_scl_low;
            sda_low <= next_sda_low;
            rd <= next_rd;
            regb <= next_regb;
            wdat <= next_wdat;
            fail <= next_fail;
            retry <= next_retry;
            resp_valid <= next_resp_valid;
            resp_nack <= next_resp_nack;
            resp_rdata <= next_resp_rdata;
        end
    end
endmodule // host_i2c_controller
`default_nettype wire

// ===== verilog/i2c_port_pkg.sv
`default_nettype none
package i2c_port_pkg;
    // link addressing
    localparam logic [6:0] TARGET_ADDR = 7'h08;
    localparam logic READ_BIT = 1'b1;
    localparam logic WRITE_BIT = 1'b0;
    // link timing
    localparam int CLK_NS = 4;
    localparam int BIT_RATE_KBPS = 400;
    localparam int BIT_NS = 1000000 / BIT_RATE_KBPS;
    localparam int QTR_NS = BIT_NS / 4;
    localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [8:0] QTR_LAST = 9'(QTR_CYC - 1);
    // frame sizes and retry limit
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] FRAME_LAST = 4'h8;
    localparam logic [1:0] RETRY_MAX = 2'h2;
    // reset values
    localparam logic LINE_IDLE = 1'b1;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [8:0] FRAME_RESET = 9'h1ff;
    typedef enum logic [3:0] {
        D_IDLE = 4'b0000,
        D_ADDR = 4'b0001,
        D_ADDR_ACK = 4'b0011,
        D_REG = 4'b0010,
        D_REG_ACK = 4'b0110,
        D_DATA = 4'b0111,
        D_DATA_ACK = 4'b0101,
        D_HOLD = 4'b0100,
        D_SEND = 4'b1100,
        D_RD_ACK = 4'b1101
    } dev_state_t;
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_START = 2'b01,
        H_BITS = 2'b11,
        H_STOP = 2'b10
    } host_state_t;
endpackage
`default_nettype wire

// ===== verilog/i2c_link_if.sv
`default_nettype none
interface i2c_link_if;
    logic host_scl_out;
    logic host_scl_oe;
    logic host_sda_out;
    logic host_sda_oe;
    logic dev_sda_out;
    logic dev_sda_oe;
    logic scl;
    logic sda;
    // open-drain wired lines with pull-up
    assign scl = host_scl_oe ? host_scl_out : 1'b1;
    assign sda = (host_sda_oe ? host_sda_out : 1'b1) & (dev_sda_oe ? dev_sda_out : 1'b1);
    modport host (
        input scl,
        input sda,
        output host_scl_out,
        output host_scl_oe,
        output host_sda_out,
        output host_sda_oe
    );
    modport device (
        input scl,
        input sda,
        output dev_sda_out,
        output dev_sda_oe
    );
endinterface
`default_nettype wire

// ===== verilog/pin_sync.sv
`default_nettype none
module pin_sync import i2c_port_pkg::*; (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic pin,
    output logic level
);
    logic [2:0] stage;
    logic next_level;

    // level follows once second and third stage agree
    always_comb begin
        next_level = level;
        if (stage[1] == stage[2]) begin
            next_level = stage[2];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            stage <= {3{LINE_IDLE}};
            level <= LINE_IDLE;
        end else begin
            stage <= {stage[1:0], pin};
            level <= next_level;
        end
    end
endmodule // pin_sync
`default_nettype wire

// ===== verilog/pmic_i2c_target.sv
// Operation
// - answer only target address 0x08
// - fast-mode timing, at most 400 kbit/s
// - seven-bit addressing only, no ten-bit decode
// - general call address is ignored
// - device is target only, never starts
// - read moves whole bytes with acknowledge
// - read byte shifted out msb first
// - stop or nack abandons the read byte
// - exactly one data byte per transaction
// - controller begins and ends every transaction
// - controller sends start then address packet
// - acknowledge only own address packet
// - controller ends and retries after nack
// - register read uses a repeated start
`default_nettype none
module pmic_i2c_target import i2c_port_pkg::*; (
    input wire logic ref_clk,
    input wire logic sys_rst,
    i2c_link_if.device link,
    output logic [7:0] reg_addr,
    output logic [7:0] wr_data,
    output logic wr_strobe,
    input wire logic [7:0] rd_data,
    output logic rd_strobe,
    output logic busy
);
    logic scl_s;
    logic sda_s;
    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    dev_state_t state;
    dev_state_t next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic rw;
    logic next_rw;
    logic drive;
    logic next_drive;
    logic [7:0] next_reg_addr;
    logic [7:0] next_wr_data;
    logic next_wr_strobe;

    pin_sync scl_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pin(link.scl),
        .level(scl_s)
    );

    pin_sync sda_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pin(link.sda),
        .level(sda_s)
    );

    // open drain: only ever pulls sda low, never touches scl
    assign link.dev_sda_out = 1'b0;
    assign link.dev_sda_oe = drive;
    assign busy = (state != D_IDLE);

    // line events
    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start_seen = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_seen = scl_s & scl_q & ~sda_q & sda_s;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_shift = shift;
        next_rw = rw;
        next_drive = drive;
        next_reg_addr = reg_addr;
        next_wr_data = wr_data;
        next_wr_strobe = 1'b0;
        rd_strobe = 1'b0;
        if (stop_seen) begin
            // stop abandons whatever is in flight
            next_state = D_IDLE;
            next_drive = 1'b0;
        end else if (start_seen) begin
            // start or repeated start reopens address phase
            next_state = D_ADDR;
            next_cnt = 4'h0;
            next_drive = 1'b0;
        end else begin
            case (state)
                D_ADDR, D_REG, D_DATA: begin
                    if (scl_rise && cnt != BYTE_BITS) begin
                        next_shift = {shift[6:0], sda_s};
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall && cnt == BYTE_BITS) begin
                        next_cnt = 4'h0;
                        if (state == D_ADDR) begin
                            // exact seven-bit match: general call and ten-bit fall out
                            if (shift[7:1] == TARGET_ADDR) begin
                                next_rw = shift[0];
                                next_drive = 1'b1;
                                next_state = D_ADDR_ACK;
                            end else begin
                                next_state = D_HOLD;
                            end
                        end else if (state == D_REG) begin
                            next_reg_addr = shift;
                            next_drive = 1'b1;
                            next_state = D_REG_ACK;
                        end else begin
                            next_wr_data = shift;
                            next_wr_strobe = 1'b1;
                            next_drive = 1'b1;
                            next_state = D_DATA_ACK;
                        end
                    end
                end
                D_ADDR_ACK: begin
                    if (scl_fall) begin
                        next_cnt = 4'h0;
                        if (rw == READ_BIT) begin
                            // present msb of selected register
                            next_shift = rd_data;
                            rd_strobe = 1'b1;
                            next_drive = ~rd_data[7];
                            next_state = D_SEND;
                        end else begin
                            next_drive = 1'b0;
                            next_state = D_REG;
                        end
                    end
                end
                D_REG_ACK: begin
                    if (scl_fall) begin
                        next_drive = 1'b0;
                        next_state = D_DATA;
                    end
                end
                D_DATA_ACK: begin
                    if (scl_fall) begin
                        // further bytes are left unanswered
                        next_drive = 1'b0;
                        next_state = D_HOLD;
                    end
                end
                D_SEND: begin
                    if (scl_rise) begin
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt == BYTE_BITS) begin
                            // release for the controller's ack bit
                            next_drive = 1'b0;
                            next_state = D_RD_ACK;
                        end else begin
                            next_shift = {shift[6:0], 1'b0};
                            next_drive = ~shift[6];
                        end
                    end
                end
                D_RD_ACK: begin
                    if (scl_rise) begin
                        // ack or nack, one byte only
                        next_state = D_HOLD;
                    end
                end
                D_IDLE, D_HOLD: begin
                    next_state = state;
                end
                default: begin
                    next_state = D_IDLE;
                    next_drive = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            scl_q <= LINE_IDLE;
            sda_q <= LINE_IDLE;
            state <= D_IDLE;
            cnt <= 4'h0;
            shift <= BYTE_RESET;
            rw <= WRITE_BIT;
            drive <= 1'b0;
            reg_addr <= BYTE_RESET;
            wr_data <= BYTE_RESET;
            wr_strobe <= 1'b0;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
            state <= next_state;
            cnt <= next_cnt;
            shift <= next_shift;
            rw <= next_rw;
            drive <= next_drive;
            reg_addr <= next_reg_addr;
            wr_data <= next_wr_data;
            wr_strobe <= next_wr_strobe;
        end
    end
endmodule // pmic_i2c_target
`default_nettype wire

// ===== verification/i2c_link_monitor.sv
`default_nettype none
module i2c_link_monitor import i2c_port_pkg::*; (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_oe
);
    localparam int MIN_PER = BIT_NS / CLK_NS;
    logic scl_q, sda_q, rise, fall, start, stop, match, rd;
    logic [3:0] bitn;
    logic [1:0] byten;
    logic [7:0] addr;
    logic [9:0] per;
    assign rise = scl & ~scl_q;
    assign fall = ~scl & scl_q;
    assign start = scl & scl_q & sda_q & ~sda;
    assign stop = scl & scl_q & ~sda_q & sda;
    assign match = addr[7:1] == TARGET_ADDR;
    assign rd = addr[0];
    // bit position within the current frame and byte count since the last start
    always_ff @(posedge ref_clk) begin
        scl_q <= sys_rst | scl;
        sda_q <= sys_rst | sda;
        per <= sys_rst ? 10'h3ff : rise ? 10'h001 : per + 10'(per != 10'h3ff);
        if (sys_rst | start) begin
            bitn <= 4'h0;
            byten <= 2'h0;
        end else if (rise) begin
            bitn <= (bitn == FRAME_LAST) ? 4'h0 : bitn + 4'h1;
            if (bitn == FRAME_LAST) begin
                byten <= byten + 2'h1;
            end
            if (byten == 2'h0 && bitn < FRAME_LAST) begin
                addr <= {addr[6:0], sda};
            end
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    sequence addr_end;
        rise && bitn == FRAME_LAST && byten == 2'h0;
    endsequence
    sequence ack_rise;
        rise && bitn == FRAME_LAST && dev_sda_oe;
    endsequence
    AST_ADDR_ACK: assert property (addr_end |-> sda == !match)
        else $error("address ack does not follow address match");
    AST_WRITE_ACK: assert property (rise && bitn == FRAME_LAST
        && byten inside {2'h1, 2'h2} && match && !rd |-> !sda)
        else $error("write byte not acknowledged");
    AST_READ_NACK: assert property (rise && bitn == FRAME_LAST
        && byten == 2'h1 && match && rd |-> sda)
        else $error("device holds line in read ack slot");
    AST_ACK_TIME: assert property (fall && bitn == FRAME_LAST
        && byten == 2'h0 && match |-> ##[1:8] dev_sda_oe)
        else $error("address ack late");
    AST_ACK_HOLD: assert property (ack_rise |-> dev_sda_oe [*8])
        else $error("ack dropped during clock high");
    AST_STABLE_HIGH: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
        else $error("device changed data while clock high");
    AST_START_QUIET: assert property (start |=> !dev_sda_oe [*8])
        else $error("device drives right after start");
    AST_STOP_RELEASE: assert property (stop |=> !dev_sda_oe [*8])
        else $error("device drives after stop");
    AST_BIT_RATE: assert property (rise |-> per >= MIN_PER)
        else $error("link clock too fast");
endmodule // i2c_link_monitor
`default_nettype wire

// ===== verification/tb_pmic_i2c_register_port.sv
`default_nettype none
module tb_pmic_i2c_register_port import i2c_port_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_read = 1'b0;
    logic [7:0] cmd_reg = 8'h00;
    logic [7:0] cmd_wdata = 8'h00;
    logic cmd_ready, resp_valid, resp_nack, wr_strobe, rd_strobe, busy;
    logic wr_strobe2, rd_strobe2, busy2, a;
    logic [7:0] resp_rdata, reg_addr, wr_data, rd_data, reg_addr2, wr_data2, rd_data2;
    logic [7:0] got, d0, r1, r2;
    logic [7:0] regs [256];
    logic [6:0] foreign [4] = '{7'h00, 7'h07, 7'h09, 7'h78};
    int err_count = 0;
    int compares = 0;
    int seed = 55;
    int wr_seen = 0;
    int rd_seen = 0;
    int wr_seen2 = 0;
    int rd_seen2 = 0;
    function automatic logic [7:0] exp_rd(input logic [7:0] r);
        return r ^ 8'h5a;
    endfunction
    i2c_link_if link ();
    i2c_link_if link2 ();
    always #2 ref_clk = ~ref_clk;
    assign rd_data = regs[reg_addr];
    assign rd_data2 = exp_rd(reg_addr2);
    always @(posedge ref_clk) begin
        if (wr_strobe === 1'b1) begin
            regs[reg_addr] <= wr_data;
            wr_seen++;
        end
        if (rd_strobe === 1'b1) begin
            rd_seen++;
        end
        if (wr_strobe2 === 1'b1) begin
            wr_seen2++;
        end
        if (rd_strobe2 === 1'b1) begin
            rd_seen2++;
        end
    end
    pmic_i2c_target i_pmic_i2c_target (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .link(link.device), .reg_addr(reg_addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
        .rd_data(rd_data), .rd_strobe(rd_strobe), .busy(busy));
    pmic_i2c_target i_pmic_i2c_target_b (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .link(link2.device), .reg_addr(reg_addr2), .wr_data(wr_data2),
        .wr_strobe(wr_strobe2), .rd_data(rd_data2), .rd_strobe(rd_strobe2), .busy(busy2));
    host_i2c_controller i_host_i2c_controller (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .link(link.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
        .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata), .resp_valid(resp_valid),
        .resp_nack(resp_nack), .resp_rdata(resp_rdata));
    i2c_link_monitor i_i2c_link_monitor (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .scl(link.scl), .sda(link.sda), .dev_sda_oe(link.dev_sda_oe));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic host_cmd(input logic rd, input logic [7:0] r, input logic [7:0] d);
        int n;
        cmd_valid = 1'b1;
        cmd_read = rd;
        cmd_reg = r;
        cmd_wdata = d;
        while (cmd_ready !== 1'b1) @(negedge ref_clk);
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        for (n = 0; n < 30000 && resp_valid !== 1'b1; n++) @(negedge ref_clk);
        check({7'h00, resp_valid}, 8'h01);
        check({7'h00, resp_nack}, 8'h00);
    endtask
    // bench link clock: 64 ns bit, changes kept off the clock edges
    task automatic bb_bit(input logic b, output logic s);
        #8 link2.host_sda_oe = ~b;
        #36 link2.host_scl_oe = 1'b0;
        #16 s = link2.sda;
        #4 link2.host_scl_oe = 1'b1;
    endtask
    // start when pre is low, stop when pre is high
    task automatic bb_cond(input logic pre);
        #8 link2.host_sda_oe = pre;
        #36 link2.host_scl_oe = 1'b0;
        #32 link2.host_sda_oe = ~pre;
        #32 link2.host_scl_oe = ~pre;
    endtask
    task automatic bb_frame(input logic [7:0] v, output logic [7:0] g, output logic ack);
        for (int i = 7; i >= 0; i--) bb_bit(v[i], g[i]);
        bb_bit(1'b1, ack);
    endtask
    task automatic bb_open(input logic [7:0] r);
        logic [7:0] g;
        logic ack;
        bb_cond(1'b0);
        bb_frame({TARGET_ADDR, WRITE_BIT}, g, ack);
        check({7'h00, ack}, 8'h00);
        bb_frame(r, g, ack);
        check({7'h00, ack}, 8'h00);
        bb_cond(1'b0);
        bb_frame({TARGET_ADDR, READ_BIT}, g, ack);
        check({7'h00, ack}, 8'h00);
    endtask
    initial begin
        link2.host_scl_out = 1'b0;
        link2.host_sda_out = 1'b0;
        link2.host_scl_oe = 1'b0;
        link2.host_sda_oe = 1'b0;
        repeat (6) @(negedge ref_clk);
        sys_rst = 1'b0;
        fork
            begin
                r1 = {1'b0, 7'($random(seed))};
                d0 = 8'($random(seed));
                host_cmd(WRITE_BIT, 8'hff, d0);
                check(reg_addr, 8'hff);
                check(wr_data, d0);
                host_cmd(WRITE_BIT, r1, ~d0);
                check(reg_addr, r1);
                check(wr_data, ~d0);
                host_cmd(READ_BIT, 8'hff, 8'h00);
                check(resp_rdata, d0);
                check(8'(wr_seen), 8'h02);
                check(8'(rd_seen), 8'h01);
                // stop reaches the target through its pin synchronisers
                repeat (8) @(negedge ref_clk);
                check({7'h00, busy}, 8'h00);
                $display("write and read test done");
            end
            begin
                #1;
                foreach (foreign[i]) begin
                    bb_cond(1'b0);
                    bb_frame({foreign[i], WRITE_BIT}, got, a);
                    bb_cond(1'b1);
                    check({7'h00, a}, 8'h01);
                end
                check({7'h00, busy2}, 8'h00);
                r2 = 8'($random(seed)) & 8'hf7;
                bb_open(r2);
                bb_frame(8'hff, got, a);
                check(got, exp_rd(r2));
                bb_cond(1'b1);
                check(reg_addr2, r2);
                bb_open(r2);
                for (int i = 7; i >= 4; i--) bb_bit(1'b1, got[i]);
                bb_cond(1'b1);
                #200;
                check({7'h00, link2.sda}, 8'h01);
                check({7'h00, busy2}, 8'h00);
                // one-byte write, then a second data byte that must go unanswered
                bb_cond(1'b0);
                bb_frame({TARGET_ADDR, WRITE_BIT}, got, a);
                bb_frame(r2, got, a);
                bb_frame(d0, got, a);
                check({7'h00, a}, 8'h00);
                bb_frame(8'h3c, got, a);
                check({7'h00, a}, 8'h01);
                bb_cond(1'b1);
                check(wr_data2, d0);
                check(8'(wr_seen2), 8'h01);
                check(8'(rd_seen2), 8'h02);
                $display("foreign address and abort test done");
            end
        join
        close_out();
    end
    initial begin
        #320000;
        err_count++;
        close_out();
    end
endmodule // tb_pmic_i2c_register_port
`default_nettype wire
